// File: hdl/osr_pkg.sv
package osr_pkg;

    // Widths of captured values
    localparam int ADDR_W = 48;
    localparam int CNT_W  = 16;
    localparam int SEL_W  = 20;
    localparam int RAND_W = 7;
    localparam int MAXHI_W = 16;
    localparam int PADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_COUNTS   = 8'h08;
    localparam logic [7:0] OFS_BRANCH   = 8'h0c;
    localparam logic [7:0] OFS_VADDR_LO = 8'h10;
    localparam logic [7:0] OFS_VADDR_HI = 8'h14;
    localparam logic [7:0] OFS_MEMFLAGS = 8'h18;
    localparam logic [7:0] OFS_MISSLAT  = 8'h1c;
    localparam logic [7:0] OFS_LIN_LO   = 8'h20;
    localparam logic [7:0] OFS_LIN_HI   = 8'h24;
    localparam logic [7:0] OFS_PHYS_LO  = 8'h28;
    localparam logic [7:0] OFS_PHYS_HI  = 8'h2c;

    // Field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_MAX_LSB   = 16;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_BUSY_BIT  = 1;
    localparam int STAT_ARM_BIT   = 2;
    localparam int CNT_TAG_LSB    = 16;
    localparam int MEM_DCMISS_BIT = 16;
    localparam int MEM_LINV_BIT   = 17;
    localparam int MEM_PHYV_BIT   = 18;

    // Values after reset, and the counter saturation value
    localparam logic [RAND_W-1:0]  LFSR_SEED  = 7'h5a;
    localparam logic [MAXHI_W-1:0] MAXHI_RST  = 16'h0010;
    localparam logic [CNT_W-1:0]   CNT_SAT    = 16'hffff;

    // Branch classification from retire
    typedef struct packed {
        logic archBranch;
        logic anyBranch;
        logic mispredict;
        logic taken;
        logic isReturn;
        logic returnMisp;
        logic resync;
    } osr_br_t;

    // Load/store attribute flags
    typedef struct packed {
        logic loadOp;
        logic storeOp;
        logic dtlbL1Miss;
        logic dtlbL2Miss;
        logic dtlbL1Hit2m;
        logic dtlbL1Hit1g;
        logic dtlbL2Hit2m;
        logic misalignedAccess;
        logic loadBankConflict;
        logic storeBankConflict;
        logic storeForwardHit;
        logic storeForwardCancel;
        logic uncacheableAccess;
        logic writeCombiningAccess;
        logic lockedAccess;
        logic missBufferHit;
    } osr_memflags_t;

    // One report from the load/store unit
    typedef struct packed {
        osr_memflags_t           flags;
        logic                    linearAddrValid;
        logic                    physAddrValid;
        logic [ADDR_W-1:0]       linearAddr;
        logic [ADDR_W-1:0]       physAddr;
    } osr_mem_t;

    // Tracking states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_TRACK = 2'b01,
        ST_HOLD  = 2'b10
    } osr_state_t;

endpackage

// File: hdl/osr_recorder.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps

module osr_recorder (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [osr_pkg::PADDR_W-1:0]   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata_q,
    output logic                               pready_q,
    output logic                               pslverr_q,
    // Decode stage
    input  wire logic                          decodeValid,
    input  wire logic [osr_pkg::ADDR_W-1:0]    decodeInstrVaddr,
    output logic                               tagArm_q,
    // Execute and retire of the tagged op
    input  wire logic                          completeTagged,
    input  wire logic                          retireTagged,
    input  wire osr_pkg::osr_br_t              retireBranch,
    input  wire logic                          flushTagged,
    // Load/store unit reports for the tagged op
    input  wire logic                          lsuTagged,
    input  wire osr_pkg::osr_mem_t             lsuInfo,
    input  wire logic                          dcMissTagged,
    input  wire logic                          dcFillTagged,
    // Sample ready
    output logic                               sampleIrq_q
);
    import osr_pkg::*;

    osr_state_t             state_q;
    logic [RAND_W-1:0]      lfsr_q;
    logic [SEL_W-1:0]       selCnt_q;
    logic [SEL_W-1:0]       selMax;
    logic                   enable_q;
    logic [MAXHI_W-1:0]     maxHi_q;
    logic [CNT_W-1:0]       tagCnt_q;
    logic [CNT_W-1:0]       compCnt_q;
    logic                   compRun_q;
    logic [CNT_W-1:0]       missCnt_q;
    logic                   missRun_q;
    logic [CNT_W-1:0]       missLat_q;
    logic                   dcMiss_q;
    logic [CNT_W-1:0]       tagToRetire_q;
    logic [CNT_W-1:0]       compToRetire_q;
    logic [ADDR_W-1:0]      vaddr_q;
    logic [6:0]             brFlags_q;
    osr_memflags_t          memFlags_q;
    logic                   linValid_q;
    logic                   physValid_q;
    logic [ADDR_W-1:0]      linAddr_q;
    logic [ADDR_W-1:0]      physAddr_q;
    logic                   tagNow;
    logic                   retireNow;
    logic                   flushNow;
    logic                   apbDone;
    logic                   apbWrite;
    logic                   clearSample;
    logic [31:0]            readData;
    logic                   readOk;
    logic [6:0]             brFinal;

    // Event qualifiers
    assign tagNow      = tagArm_q && decodeValid && (state_q == ST_IDLE);
    assign retireNow   = retireTagged && (state_q == ST_TRACK);
    assign flushNow    = flushTagged && (state_q == ST_TRACK) && !retireNow;
    assign selMax      = {maxHi_q, 4'h0};
    assign apbDone     = psel && penable && pready_q;
    assign apbWrite    = apbDone && pwrite;
    assign clearSample = apbWrite && (paddr == OFS_STATUS)
                         && pwdata[STAT_VALID_BIT];

    // Pseudo-random source for reload
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lfsr_q <= LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[RAND_W-2:0], lfsr_q[6] ^ lfsr_q[5]};
        end
    end

    // Selection counter and arming
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            selCnt_q <= '0;
            tagArm_q <= 1'b0;
        end else if (!enable_q) begin
            selCnt_q <= '0;
            tagArm_q <= 1'b0;
        end else if (flushNow) begin
            selCnt_q <= {{(SEL_W-RAND_W){1'b0}}, lfsr_q};
        end else if (tagNow) begin
            tagArm_q <= 1'b0;
        end else if (state_q == ST_IDLE && !tagArm_q) begin
            if (selCnt_q >= selMax) begin
                selCnt_q <= '0;
                tagArm_q <= 1'b1;
            end else begin
                selCnt_q <= selCnt_q + 20'h0_0001;
            end
        end
    end

    // Tracking state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q     <= ST_IDLE;
            sampleIrq_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (tagNow) begin
                        state_q <= ST_TRACK;
                    end
                end
                ST_TRACK: begin
                    if (retireNow) begin
                        state_q     <= ST_HOLD;
                        sampleIrq_q <= 1'b1;
                    end else if (flushTagged) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    if (clearSample) begin
                        state_q     <= ST_IDLE;
                        sampleIrq_q <= 1'b0;
                    end
                end
                default: begin
                    state_q     <= ST_IDLE;
                    sampleIrq_q <= 1'b0;
                end
            endcase
        end
    end

    // Tag-to-retire and completion-to-retire counters
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tagCnt_q  <= '0;
            compCnt_q <= '0;
            compRun_q <= 1'b0;
        end else if (tagNow) begin
            tagCnt_q  <= '0;
            compCnt_q <= '0;
            compRun_q <= 1'b0;
        end else if (state_q == ST_TRACK) begin
            if (tagCnt_q != CNT_SAT) begin
                tagCnt_q <= tagCnt_q + 16'h0001;
            end
            if (completeTagged && !compRun_q) begin
                compRun_q <= 1'b1;
                compCnt_q <= '0;
            end else if (compRun_q && compCnt_q != CNT_SAT) begin
                compCnt_q <= compCnt_q + 16'h0001;
            end
        end
    end

    // Data cache miss latency
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            missCnt_q <= '0;
            missRun_q <= 1'b0;
            missLat_q <= '0;
            dcMiss_q  <= 1'b0;
        end else if (tagNow) begin
            missCnt_q <= '0;
            missRun_q <= 1'b0;
            missLat_q <= '0;
            dcMiss_q  <= 1'b0;
        end else if (state_q == ST_TRACK) begin
            if (dcMissTagged && !dcMiss_q) begin
                dcMiss_q  <= 1'b1;
                missRun_q <= 1'b1;
                missCnt_q <= '0;
            end else if (missRun_q && dcFillTagged) begin
                missRun_q <= 1'b0;
                missLat_q <= (missCnt_q == CNT_SAT) ? CNT_SAT
                                                    : missCnt_q + 16'h0001;
            end else if (missRun_q && missCnt_q != CNT_SAT) begin
                missCnt_q <= missCnt_q + 16'h0001;
            end
        end
    end

    // Branch classification after resync and return fix-ups
    always_comb begin
        brFinal = 7'h00;
        brFinal[6] = retireBranch.archBranch;
        if (retireBranch.anyBranch) begin
            brFinal[5] = retireBranch.mispredict;
            brFinal[4] = retireBranch.taken;
        end
        brFinal[3] = retireBranch.isReturn;
        brFinal[2] = retireBranch.isReturn && retireBranch.returnMisp;
        if (retireBranch.resync) begin
            brFinal[1] = 1'b1;
            brFinal[5] = 1'b0;
            brFinal[4] = 1'b1;
        end
        brFinal[0] = 1'b0;
    end

    // Retire-time capture of counts and classification
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tagToRetire_q  <= '0;
            compToRetire_q <= '0;
            brFlags_q      <= '0;
        end else if (retireNow) begin
            tagToRetire_q  <= (tagCnt_q == CNT_SAT) ? CNT_SAT
                                                    : tagCnt_q + 16'h0001;
            compToRetire_q <= !compRun_q ? '0
                            : (compCnt_q == CNT_SAT) ? CNT_SAT
                                                     : compCnt_q + 16'h0001;
            brFlags_q      <= brFinal;
        end
    end

    // Parent address captured at tagging
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vaddr_q <= '0;
        end else if (tagNow) begin
            vaddr_q <= decodeInstrVaddr;
        end
    end

    // Load/store attributes, accumulated while tracking
    always_ff @(posedge clk) begin
        if (!reset_n || tagNow) begin
            memFlags_q  <= '0;
            linValid_q  <= 1'b0;
            physValid_q <= 1'b0;
            linAddr_q   <= '0;
            physAddr_q  <= '0;
        end else if (lsuTagged && state_q == ST_TRACK) begin
            // load and store kept as given
            memFlags_q <= memFlags_q | lsuInfo.flags;
            if (lsuInfo.linearAddrValid) begin
                linValid_q <= 1'b1;
                linAddr_q  <= lsuInfo.linearAddr;
            end
            if (lsuInfo.physAddrValid) begin
                physValid_q <= 1'b1;
                physAddr_q  <= lsuInfo.physAddr;
            end
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_q <= 1'b0;
            maxHi_q  <= MAXHI_RST;
        end else if (apbWrite && paddr == OFS_CTRL) begin
            enable_q <= pwdata[CTRL_EN_BIT];
            maxHi_q  <= pwdata[CTRL_MAX_LSB +: MAXHI_W];
        end
    end

    // Read decode
    always_comb begin
        readData = 32'h0000_0000;
        readOk   = 1'b1;
        case (paddr)
            OFS_CTRL: begin
                readData[CTRL_EN_BIT]                = enable_q;
                readData[CTRL_MAX_LSB +: MAXHI_W]    = maxHi_q;
            end
            OFS_STATUS: begin
                readData[STAT_VALID_BIT] = (state_q == ST_HOLD);
                readData[STAT_BUSY_BIT]  = (state_q == ST_TRACK);
                readData[STAT_ARM_BIT]   = tagArm_q;
            end
            OFS_COUNTS: begin
                readData = {tagToRetire_q, compToRetire_q};
            end
            OFS_BRANCH:   readData[6:0] = brFlags_q;
            OFS_VADDR_LO: readData = vaddr_q[31:0];
            OFS_VADDR_HI: readData[15:0] = vaddr_q[ADDR_W-1:32];
            OFS_MEMFLAGS: begin
                readData[15:0]           = memFlags_q;
                readData[MEM_DCMISS_BIT] = dcMiss_q;
                readData[MEM_LINV_BIT]   = linValid_q;
                readData[MEM_PHYV_BIT]   = physValid_q;
            end
            // Latency meaningless for pure stores
            OFS_MISSLAT: begin
                if (memFlags_q.loadOp) begin
                    readData[15:0] = missLat_q;
                end
            end
            OFS_LIN_LO:  readData = linAddr_q[31:0];
            OFS_LIN_HI:  readData[15:0] = linAddr_q[ADDR_W-1:32];
            OFS_PHYS_LO: readData = physAddr_q[31:0];
            OFS_PHYS_HI: readData[15:0] = physAddr_q[ADDR_W-1:32];
            default:     readOk = 1'b0;
        endcase
    end

    // APB handshake, one wait state per access
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= !readOk;
            prdata_q  <= pwrite ? 32'h0000_0000 : readData;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
    end

endmodule // osr_recorder

// File: verif/osr_tb_pkg.sv
package osr_tb_pkg;

    // One op as the pipeline model plays it, with its branch readback
    typedef struct packed {
        logic [osr_pkg::ADDR_W-1:0] va;
        osr_pkg::osr_br_t           br;
        logic [6:0]                 xbr;
        osr_pkg::osr_mem_t          mem;
        logic [7:0]                 comp;
        logic [7:0]                 ret;
        logic [7:0]                 miss;
        logic [3:0]                 stall;
        logic                       flush;
    } osr_op_t;

endpackage

// File: verif/osr_pipe_model.sv
`timescale 1ns/10ps
module osr_pipe_model
    import osr_pkg::*;
(
    // Clock and op to play
    input  wire logic                  clk,
    input  wire osr_tb_pkg::osr_op_t   op,
    // Arm from the recorder
    input  wire logic                  tagArm_q,
    // Decode, execute and retire events
    output logic                       decodeValid,
    output logic [osr_pkg::ADDR_W-1:0] decodeInstrVaddr,
    output logic                       completeTagged,
    output logic                       retireTagged,
    output osr_pkg::osr_br_t           retireBranch,
    output logic                       flushTagged,
    // Load/store unit events
    output logic                       lsuTagged,
    output osr_pkg::osr_mem_t          lsuInfo,
    output logic                       dcMissTagged,
    output logic                       dcFillTagged
);
    int   n;
    int   k = 0;
    int   w = 0;
    logic tagNow;
    logic nd;

    // Op leaves decode after a stall; later events counted from the tag
    always @(posedge clk) begin
        tagNow = tagArm_q && decodeValid;
        n = tagNow ? 1 : (k != 0 && k < op.ret) ? k + 1 : 0;
        k <= n;
        w <= tagArm_q ? w + 1 : 0;
        nd = tagArm_q && !tagNow && w >= op.stall;
        decodeValid <= nd;
        // Address is junk whenever no op is offered
        decodeInstrVaddr <= nd ? op.va : ~op.va;
        completeTagged <= n != 0 && n == op.comp;
        retireTagged <= n != 0 && n == op.ret && !op.flush;
        flushTagged <= n != 0 && n == op.ret && op.flush;
        retireBranch <= n == op.ret ? op.br : ~op.br;
        lsuTagged <= n == 1;
        lsuInfo <= n == 1 ? op.mem : ~op.mem;
        dcMissTagged <= n == 2 && op.miss != 8'h00;
        dcFillTagged <= n == 2 + op.miss && op.miss != 8'h00;
    end
endmodule // osr_pipe_model

// File: verif/osr_recorder_properties.sv
`timescale 1ns/10ps
module osr_recorder_properties
    import osr_pkg::*;
(
    // Clock and reset
    input wire logic                        clk,
    input wire logic                        reset_n,
    // Register bus
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [osr_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata_q,
    input wire logic                        pready_q,
    input wire logic                        pslverr_q,
    // Pipeline side
    input wire logic                        decodeValid,
    input wire logic                        tagArm_q,
    input wire logic                        retireTagged,
    input wire logic                        flushTagged,
    input wire logic                        sampleIrq_q
);
    logic clr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Software clear of a held sample
    assign clr = psel && penable && pwrite && pready_q
                 && paddr == OFS_STATUS && pwdata[0];

    // Bus answer timing and decode
    a_bus_one_wait: assert property (psel && $rose(penable) |=> pready_q)
        else $error("bus answer not one cycle after access start");
    a_rdata_idle: assert property (!pready_q |-> prdata_q == 32'h0000_0000
                                   && !pslverr_q)
        else $error("read data or error outside answer cycle");
    a_err_decode: assert property (pready_q && paddr[1:0] == 2'b00
                                   |-> pslverr_q == (paddr > OFS_PHYS_HI))
        else $error("error flag disagrees with address map");
    // Sampling flow
    a_tag_disarm: assert property (tagArm_q && decodeValid |=> !tagArm_q)
        else $error("arm stayed up after tagging");
    a_retire_irq: assert property (retireTagged && !sampleIrq_q |=> sampleIrq_q)
        else $error("no sample flag after retire");
    a_flush_drop: assert property (flushTagged && !retireTagged && !sampleIrq_q
                                   |=> !sampleIrq_q [*2])
        else $error("flushed op produced a sample");
    a_hold_steady: assert property (sampleIrq_q && !clr && !$past(clr)
                                    |=> sampleIrq_q)
        else $error("held sample dropped without clear");
    a_clear_release: assert property (sampleIrq_q && clr
                                      |-> ##[1:2] !sampleIrq_q)
        else $error("clear did not release the sample");
    a_hold_no_arm: assert property (sampleIrq_q |-> !tagArm_q)
        else $error("armed while a sample is held");
endmodule // osr_recorder_properties

bind osr_recorder osr_recorder_properties u_props (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .decodeValid, .tagArm_q, .retireTagged,
    .flushTagged, .sampleIrq_q
);

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
    import osr_pkg::*;
    import osr_tb_pkg::*;

    // Clock, reset and bus
    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0000_0000;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    // Pipeline
    logic               decodeValid;
    logic [ADDR_W-1:0]  decodeInstrVaddr;
    logic               tagArm_q;
    logic               completeTagged;
    logic               retireTagged;
    osr_br_t            retireBranch;
    logic               flushTagged;
    logic               lsuTagged;
    osr_mem_t           lsuInfo;
    logic               dcMissTagged;
    logic               dcFillTagged;
    logic               sampleIrq_q;
    // Stimulus rows and bookkeeping
    osr_op_t            op = '0;
    osr_op_t            rows [7];
    osr_op_t            fo;
    int                 fails = 0;
    int                 nChecks = 0;
    logic [31:0]        q;
    logic               e;

    // Core clock
    always #20 clk = ~clk;

    osr_recorder dut (
        .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_q, .pready_q, .pslverr_q, .decodeValid, .decodeInstrVaddr,
        .tagArm_q, .completeTagged, .retireTagged, .retireBranch,
        .flushTagged, .lsuTagged, .lsuInfo, .dcMissTagged, .dcFillTagged,
        .sampleIrq_q
    );
    osr_pipe_model pipe (
        .clk, .op, .tagArm_q, .decodeValid, .decodeInstrVaddr,
        .completeTagged, .retireTagged, .retireBranch, .flushTagged,
        .lsuTagged, .lsuInfo, .dcMissTagged, .dcFillTagged
    );

    // Verdict and end of run
    task automatic finish_test();
        $display("checks=%0d fails=%0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Compare one word
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus transfer; leaves one idle cycle after it
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready_q !== 1'b1 && i < 50);
        q = prdata_q;
        e = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (i >= 50) begin
            cmp({31'h0000_0000, pready_q}, 32'h0000_0001);
            finish_test();
        end
    endtask

    // Read and compare
    task automatic chk(input logic [7:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0000_0000);
        cmp(q, x);
    endtask

    // Bounded wait for the sample flag, the flush pulse or the arm
    task automatic wait_ev(input logic [1:0] sel);
        int i;
        for (i = 0; i < 2000 && (sel == 2'd2 ? tagArm_q : sel == 2'd1 ?
             flushTagged : sampleIrq_q) !== 1'b1; i++)
            @(posedge clk);
        if (i == 2000) begin
            cmp(32'h0000_0000, 32'h0000_0001);
            finish_test();
        end
    endtask

    // Build one op row with its readback
    function automatic osr_op_t mk(logic [6:0] b, logic [6:0] xb,
            logic [17:0] f, logic [7:0] c, logic [7:0] r, logic [7:0] m);
        return '{va: {b, r, 33'h0_0000_4000}, br: b, xbr: xb,
                 mem: '{f[17:2], f[1], f[0], {f, 22'h00_1230, r},
                        {r, 22'h3a_5c00, f}},
                 comp: c, ret: r, miss: m, stall: r[3:0], flush: 1'b0};
    endfunction

    // Read back a held sample, then release it
    task automatic check_sample(input osr_op_t o);
        osr_mem_t m;
        m = o.mem;
        wait_ev(1'b0);
        chk(OFS_COUNTS, {8'h00, o.ret, 8'h00, o.ret - o.comp});
        chk(OFS_BRANCH, {25'h000_0000, o.xbr});
        chk(OFS_VADDR_LO, o.va[31:0]);
        chk(OFS_VADDR_HI, {16'h0000, o.va[47:32]});
        chk(OFS_MEMFLAGS, {13'h0000, m.physAddrValid, m.linearAddrValid,
            o.miss != 8'h00, m.flags});
        chk(OFS_MISSLAT, m.flags.loadOp ? {24'h00_0000, o.miss} : 32'h0000_0000);
        if (m.linearAddrValid) begin
            chk(OFS_LIN_LO, m.linearAddr[31:0]);
            chk(OFS_LIN_HI, {16'h0000, m.linearAddr[47:32]});
        end
        if (m.physAddrValid) begin
            chk(OFS_PHYS_LO, m.physAddr[31:0]);
            chk(OFS_PHYS_HI, {16'h0000, m.physAddr[47:32]});
        end
        apb(OFS_STATUS, 1'b1, 32'h0000_0001);
        chk(OFS_STATUS, 32'h0000_0000);
    endtask

    // Main sequence
    initial begin
        rows[0] = mk(7'h00, 7'h00, 18'h3_0003, 8'h03, 8'h0c, 8'h04);
        rows[1] = mk(7'h78, 7'h70, 18'h3_ffff, 8'h05, 8'h09, 8'h00);
        rows[2] = mk(7'h6e, 7'h5c, 18'h2_0003, 8'h01, 8'h06, 8'h00);
        rows[3] = mk(7'h30, 7'h20, 18'h1_0001, 8'h02, 8'h08, 8'h03);
        rows[4] = mk(7'h11, 7'h12, 18'h1_5556, 8'h04, 8'h04, 8'h00);
        rows[5] = mk(7'h62, 7'h40, 18'h2_aaa8, 8'h02, 8'h07, 8'h00);
        rows[6] = mk(7'h18, 7'h00, 18'h0_0000, 8'h01, 8'hff, 8'h00);
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // Reset values, read-only and unmapped places
        chk(OFS_CTRL, 32'h0010_0000);
        chk(OFS_STATUS, 32'h0000_0000);
        apb(OFS_COUNTS, 1'b1, 32'hffff_ffff);
        chk(OFS_COUNTS, 32'h0000_0000);
        chk(8'h30, 32'h0000_0000);
        cmp({31'h0000_0000, e}, 32'h0000_0001);
        apb(OFS_CTRL, 1'b1, 32'h0001_0001);
        chk(OFS_CTRL, 32'h0001_0001);
        $display("register test done");
        // Ordinary ops, one sample each
        for (int i = 0; i < 7; i++) begin
            op <= rows[i];
            check_sample(rows[i]);
            $display("row %0d done", i);
        end
        // Flushed op is dropped, the next tag reports alone
        fo = mk(7'h78, 7'h70, 18'h3_ffff, 8'h02, 8'h05, 8'h00);
        fo.flush = 1'b1;
        op <= fo;
        wait_ev(1'b1);
        op <= rows[2];
        repeat (2) @(posedge clk);
        cmp({31'h0000_0000, sampleIrq_q}, 32'h0000_0000);
        check_sample(rows[2]);
        $display("flush test done");
        // Status while armed and while tracking, then reset in mid-sample
        op <= rows[6];
        wait_ev(2'd2);
        chk(OFS_STATUS, 32'h0000_0004);
        repeat (16) @(posedge clk);
        chk(OFS_STATUS, 32'h0000_0002);
        reset_n <= 1'b0;
        op <= '0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk(OFS_STATUS, 32'h0000_0000);
        chk(OFS_CTRL, 32'h0010_0000);
        chk(OFS_COUNTS, 32'h0000_0000);
        cmp({31'h0000_0000, sampleIrq_q}, 32'h0000_0000);
        $display("reset test done");
        finish_test();
    end
endmodule // tb
